// *** logic/eeprom_seq_defs.svh ***
// timing-free constants for the sequential read slave
`ifndef EEPROM_SEQ_DEFS_SVH
`define EEPROM_SEQ_DEFS_SVH

`define SLAVE_TYPE_CODE 4'hA
`define LAST_BIT_IDX    3'h7
`define FIRST_BIT_IDX   3'h0
`define DIR_READ        1'b1
`define ACK_LEVEL       1'b0
`define DEF_ADDR_W      11
`define MAX_ADDR_W      11
`define DEF_DATA_W      8
`define SDA_OUT_LEVEL   1'b0

`endif

// *** logic/eeprom_seq_pkg.sv ***
// types shared by the sequential read slave
`default_nettype none
package eeprom_seq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_DEVADDR   = 3'b001,
    ST_DEVACK    = 3'b010,
    ST_WORDADDR  = 3'b011,
    ST_WORDACK   = 3'b100,
    ST_TXBYTE    = 3'b101,
    ST_MASTERACK = 3'b110,
    ST_WAITSTOP  = 3'b111
  } link_state_t;

endpackage : eeprom_seq_pkg
`default_nettype wire

// *** logic/eeprom_mem_array.sv ***
// byte array with one synchronous read and one write port
`timescale 1ns/10ps
`default_nettype none
module eeprom_mem_array #(
  parameter int ADDR_W = 11,
  parameter int DATA_W = 8
) (
  input  wire logic              clk,    // core clock
  input  wire logic [ADDR_W-1:0] rdAddr, // read address
  output var  logic [DATA_W-1:0] rdData, // registered read data
  input  wire logic              wrEn,   // write strobe
  input  wire logic [ADDR_W-1:0] wrAddr, // write address
  input  wire logic [DATA_W-1:0] wrData  // write data
);

  logic [DATA_W-1:0] cells [0:(1<<ADDR_W)-1];

  always_ff @(posedge clk) begin
    if (wrEn) begin
      cells[wrAddr] <= wrData;
    end
  end

  always_ff @(posedge clk) begin
    rdData <= cells[rdAddr];
  end

endmodule : eeprom_mem_array
`default_nettype wire

// *** logic/eeprom_sequential_read.sv ***
// two-wire eeprom slave: addressing, random and sequential read
//
// Contract
// - sequential read starts from a current or random read location
// - every master acknowledge makes the device send the next byte
// - address counter advances by one after every byte sent
// - counter wraps to zero past the top address of the density
// - slave address lsb one means read, zero means write
// - acknowledge address match in ninth clock, else stay silent
// - counter holds last accessed address plus one
`timescale 1ns/10ps
`default_nettype none
`include "eeprom_seq_defs.svh"
module eeprom_sequential_read
  import eeprom_seq_pkg::*;
#(
  parameter int ADDR_W = `DEF_ADDR_W,
  parameter int DATA_W = `DEF_DATA_W
) (
  input  wire logic              ref_clk,  // core clock, 200 MHz
  input  wire logic              rst,      // sync reset, active high
  input  wire logic              scl,      // bus clock, link clock
  input  wire logic              sdaIn,    // bus data level
  output var  logic              sdaOut,   // driven level, always low
  output var  logic              sdaOe,    // high while pulling SDA low
  input  wire logic [2:0]        devPins,  // hard-wired address pins
  input  wire logic              loadEn,   // array preload strobe
  input  wire logic [ADDR_W-1:0] loadAddr, // preload address
  input  wire logic [DATA_W-1:0] loadData  // preload data
);

  ////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic slaveMatch(input logic [7:0] b,
                                      input logic [2:0] pins);
    logic ok;
    ok = (b[7:4] == `SLAVE_TYPE_CODE);
    for (int i = 0; i < 3; i++) begin
      if (i + 8 >= ADDR_W) begin
        ok = ok & (b[i+1] == pins[i]);
      end
    end
    return ok;
  endfunction : slaveMatch

  function automatic logic [ADDR_W-1:0] wordAddr(input logic [2:0] page,
                                                 input logic [7:0] lo);
    logic [`MAX_ADDR_W-1:0] full;
    full = {page, lo};
    return full[ADDR_W-1:0];
  endfunction : wordAddr

  ////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [2:0] sclSync;
  logic [2:0] sdaSync;
  logic [2:0] pinsMeta;
  logic [2:0] pinsSync;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sclSync <= 3'h7;
      sdaSync <= 3'h7;
    end else begin
      sclSync <= {sclSync[1:0], scl};
      sdaSync <= {sdaSync[1:0], sdaIn};
    end
  end

  always_ff @(posedge ref_clk) begin
    pinsMeta <= devPins;
    pinsSync <= pinsMeta;
  end

  logic sclRise;
  logic sclNow;
  logic sdaNow;
  logic startSeen;
  logic stopSeen;

  assign sclNow    = sclSync[1];
  assign sdaNow    = sdaSync[1];
  assign sclRise   = sclNow & ~sclSync[2];
  assign startSeen = sclSync[1] & sclSync[2] & sdaSync[2] & ~sdaSync[1];
  assign stopSeen  = sclSync[1] & sclSync[2] & ~sdaSync[2] & sdaSync[1];

  ////////////////////////////////////////////////////////////////////////
  // protocol engine

  link_state_t       state_reg;
  logic [2:0]        bitCnt_reg;
  logic [7:0]        shiftIn_reg;
  logic [DATA_W-1:0] txShift_reg;
  logic [ADDR_W-1:0] addrCnt_reg;
  logic [2:0]        page_reg;
  logic              isRead_reg;
  logic              driveLow_reg;
  logic [DATA_W-1:0] readData;
  logic [7:0]        byteIn;

  assign byteIn = {shiftIn_reg[6:0], sdaNow};

  eeprom_mem_array #(
    .ADDR_W (ADDR_W),
    .DATA_W (DATA_W)
  ) memArray (
    .clk    (ref_clk),
    .rdAddr (addrCnt_reg),
    .rdData (readData),
    .wrEn   (loadEn),
    .wrAddr (loadAddr),
    .wrData (loadData)
  );

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      shiftIn_reg <= 8'h00;
    end else if (sclRise) begin
      shiftIn_reg <= byteIn;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg    <= ST_IDLE;
      bitCnt_reg   <= `FIRST_BIT_IDX;
      txShift_reg  <= '0;
      addrCnt_reg  <= '0;
      page_reg     <= 3'h0;
      isRead_reg   <= 1'b0;
      driveLow_reg <= 1'b0;
    end else if (startSeen) begin
      state_reg    <= ST_DEVADDR;
      bitCnt_reg   <= `FIRST_BIT_IDX;
      driveLow_reg <= 1'b0;
    end else if (stopSeen) begin
      state_reg    <= ST_IDLE;
      driveLow_reg <= 1'b0;
    end else if (sclRise) begin
      case (state_reg)
        ST_DEVADDR: begin
          bitCnt_reg <= bitCnt_reg + 3'h1;
          if (bitCnt_reg == `LAST_BIT_IDX) begin
            if (slaveMatch(byteIn, pinsSync)) begin
              driveLow_reg <= 1'b1;
              isRead_reg   <= (byteIn[0] == `DIR_READ);
              page_reg     <= byteIn[3:1];
              state_reg    <= ST_DEVACK;
            end else begin
              state_reg <= ST_WAITSTOP;
            end
          end
        end
        ST_DEVACK, ST_MASTERACK: begin
          bitCnt_reg <= `FIRST_BIT_IDX;
          if (state_reg == ST_DEVACK && !isRead_reg) begin
            driveLow_reg <= 1'b0;
            state_reg    <= ST_WORDADDR;
          end else if (state_reg == ST_DEVACK || sdaNow == `ACK_LEVEL) begin
            txShift_reg  <= readData;
            driveLow_reg <= ~readData[DATA_W-1];
            addrCnt_reg  <= addrCnt_reg + 1'b1;
            state_reg    <= ST_TXBYTE;
          end else begin
            driveLow_reg <= 1'b0;
            state_reg    <= ST_WAITSTOP;
          end
        end
        ST_WORDADDR: begin
          bitCnt_reg <= bitCnt_reg + 3'h1;
          if (bitCnt_reg == `LAST_BIT_IDX) begin
            addrCnt_reg  <= wordAddr(page_reg, byteIn);
            driveLow_reg <= 1'b1;
            state_reg    <= ST_WORDACK;
          end
        end
        ST_WORDACK: begin
          driveLow_reg <= 1'b0;
          state_reg    <= ST_WAITSTOP;
        end
        ST_TXBYTE: begin
          bitCnt_reg <= bitCnt_reg + 3'h1;
          if (bitCnt_reg == `LAST_BIT_IDX) begin
            driveLow_reg <= 1'b0;
            state_reg    <= ST_MASTERACK;
          end else begin
            driveLow_reg <= ~txShift_reg[DATA_W-2];
            txShift_reg  <= txShift_reg << 1;
          end
        end
        default: begin
          driveLow_reg <= 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      sdaOut <= `SDA_OUT_LEVEL;
    end else begin
      sdaOut <= `SDA_OUT_LEVEL;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // link domain: pin driver changes only on SCL falling edge

  // drive request is settled during SCL high, so it is stable here
  always_ff @(negedge scl) begin
    sdaOe <= driveLow_reg;
  end

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  logic addrLast;
  assign addrLast = (bitCnt_reg == `LAST_BIT_IDX) & sclRise
                  & ~startSeen & ~stopSeen;

  ack_on_match_a: assert property (
    (state_reg == ST_DEVADDR) && addrLast && slaveMatch(byteIn, pinsSync)
    |=> driveLow_reg && state_reg == ST_DEVACK)
    else $error("matching address not acknowledged");

  silent_mismatch_a: assert property (
    (state_reg == ST_DEVADDR) && addrLast && !slaveMatch(byteIn, pinsSync)
    |=> !driveLow_reg && state_reg == ST_WAITSTOP)
    else $error("device answered a foreign address");

  dir_select_a: assert property (
    (state_reg == ST_DEVADDR) && addrLast && slaveMatch(byteIn, pinsSync)
    |=> isRead_reg == $past(byteIn[0]))
    else $error("direction bit not taken");

  first_byte_a: assert property (
    (state_reg == ST_DEVACK) && isRead_reg && sclRise
    && !startSeen && !stopSeen
    |=> txShift_reg == $past(readData) && state_reg == ST_TXBYTE)
    else $error("first byte not from counter location");

  counter_step_a: assert property (
    $rose(state_reg == ST_TXBYTE)
    |-> addrCnt_reg == ADDR_W'($past(addrCnt_reg) + 1'b1))
    else $error("counter did not advance by one");

  counter_wrap_a: assert property (
    $rose(state_reg == ST_TXBYTE) && $past(addrCnt_reg) == '1
    |-> addrCnt_reg == '0)
    else $error("counter did not wrap to zero");

  next_on_ack_a: assert property (
    (state_reg == ST_MASTERACK) && sclRise && !sdaNow
    && !startSeen && !stopSeen
    |=> state_reg == ST_TXBYTE ##1 (state_reg == ST_TXBYTE)[*2])
    else $error("acknowledge did not start next byte");

  release_ack_slot_a: assert property (
    (state_reg == ST_MASTERACK) |-> !driveLow_reg
    && (!sclRise || !sdaOe))
    else $error("SDA held during master acknowledge slot");

  last_after_nack_a: assert property (
    (state_reg == ST_MASTERACK) && sclRise && sdaNow
    && !startSeen && !stopSeen
    |=> $stable(addrCnt_reg) && state_reg == ST_WAITSTOP)
    else $error("counter moved after final byte");

  read_first_c: cover property (
    (state_reg == ST_DEVACK) && isRead_reg ##1 state_reg == ST_TXBYTE);
  seq_continue_c: cover property (
    (state_reg == ST_MASTERACK) ##[1:400] state_reg == ST_TXBYTE);
  wrap_c: cover property (
    ($past(addrCnt_reg) == '1) && (addrCnt_reg == '0));
  random_set_c: cover property (state_reg == ST_WORDACK);

endmodule : eeprom_sequential_read
`default_nettype wire

// *** dv/bus_master_model.sv ***
// two-wire bus master model, link clock source
`timescale 1ns/10ps
`default_nettype none
module bus_master_model #(
  parameter int Q = 301 // quarter bit time, ns
) (
  output var  logic scl,   // bus clock, idle high
  output var  logic mstOe, // high while pulling SDA low
  input  wire logic sda    // resolved wire level
);
  initial begin
    scl = 1'b1;
    mstOe = 1'b0;
  end
  // one low pulse, data left released
  task automatic idle_pulse();
    scl = 1'b0;
    #Q scl = 1'b1;
    #Q;
  endtask : idle_pulse
  // also used as repeated start
  task automatic bus_start();
    mstOe = 1'b0;
    #Q scl = 1'b1;
    #Q mstOe = 1'b1;
    #Q scl = 1'b0;
    #Q;
  endtask : bus_start
  task automatic bus_stop();
    mstOe = 1'b1;
    #Q scl = 1'b1;
    #Q mstOe = 1'b0;
    #(2*Q);
  endtask : bus_stop
  // sda sampled twice in the high phase
  task automatic bus_bit(input logic b, output logic r, output logic s);
    logic r2;
    mstOe = ~b;
    #Q scl = 1'b1;
    #Q r = sda;
    #(Q-1) r2 = sda;
    #1 scl = 1'b0;
    #Q;
    s = (r === r2);
  endtask : bus_bit
  task automatic put_byte(input logic [7:0] b, output logic ack);
    logic r, s;
    for (int i = 7; i >= 0; i--) bus_bit(b[i], r, s);
    bus_bit(1'b1, r, s);
    ack = (r === 1'b0);
  endtask : put_byte
  // more: ack for another byte, else no ack
  task automatic get_byte(input logic more, output logic [7:0] d,
                          output logic ok);
    logic r, s;
    ok = 1'b1;
    for (int i = 7; i >= 0; i--) begin
      bus_bit(1'b1, r, s);
      d[i] = r;
      ok = ok & s;
    end
    bus_bit(~more, r, s);
    ok = ok & s & (r === ~more);
  endtask : get_byte
endmodule : bus_master_model
`default_nettype wire

// *** dv/eeprom_sequential_read_tb.sv ***
// bench for the sequential read slave
`timescale 1ns/10ps
`default_nettype none
module eeprom_sequential_read_tb;
  localparam int AW = 7;
  localparam logic [2:0] PINS = 3'h5;
  logic          refClk = 1'b0;
  logic          rst = 1'b1;
  logic          loadEn = 1'b0;
  logic [AW-1:0] loadAddr = '0;
  logic [7:0]    loadData = 8'h00;
  logic          scl, mstOe, sdaOe, sdaOut;
  wire  logic    sdaWire;
  int            mismatches = 0;
  int            nChecks = 0;
  always #2.5 refClk = ~refClk;
  // pull-up; device shows its level while enabled, master pulls low
  assign sdaWire = (sdaOe ? sdaOut : 1'b1) & ~mstOe;
  bus_master_model m (.scl(scl), .mstOe(mstOe), .sda(sdaWire));
  eeprom_sequential_read #(.ADDR_W(AW), .DATA_W(8)) dut (
    .ref_clk(refClk), .rst(rst), .scl(scl), .sdaIn(sdaWire),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .devPins(PINS),
    .loadEn(loadEn), .loadAddr(loadAddr), .loadData(loadData));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] pat(int a);
    return 8'(a * 37 + 17);
  endfunction : pat
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    nChecks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic end_sim();
    if (mismatches == 0 && nChecks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_sim
  task automatic preload();
    for (int a = 0; a < 2**AW; a++) begin
      @(posedge refClk);
      loadEn <= 1'b1;
      loadAddr <= AW'(a);
      loadData <= pat(a);
    end
    @(posedge refClk);
    loadEn <= 1'b0;
  endtask : preload
  ////////////////////////////////////////////////////////////////////////
  task automatic t_refuse();
    logic ack;
    m.bus_start();
    m.put_byte({4'hA, 3'h2, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
    m.bus_stop();
    m.bus_start();
    m.put_byte({4'hB, PINS, 1'b1}, ack);
    check({7'h00, ack}, 8'h00);
    m.bus_stop();
    check({7'h00, sdaOe}, 8'h00);
  endtask : t_refuse
  // random read near the top, runs over the wrap
  task automatic t_random();
    logic ack, ok;
    logic [7:0] d;
    m.bus_start();
    m.put_byte({4'hA, PINS, 1'b0}, ack);
    check({7'h00, ack}, 8'h01);
    m.put_byte(8'h7D, ack);
    check({7'h00, ack}, 8'h01);
    m.bus_start();
    m.put_byte({4'hA, PINS, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    for (int k = 0; k < 4; k++) begin
      m.get_byte(k < 3, d, ok);
      check(d, pat((125 + k) % 2**AW));
      check({7'h00, ok}, 8'h01);
    end
    m.bus_stop();
    check({7'h00, sdaOe}, 8'h00);
  endtask : t_random
  // counter left at 1 by the read of address 0
  task automatic t_current();
    logic ack, ok;
    logic [7:0] d;
    m.bus_start();
    m.put_byte({4'hA, PINS, 1'b1}, ack);
    check({7'h00, ack}, 8'h01);
    for (int k = 0; k < 2; k++) begin
      m.get_byte(k < 1, d, ok);
      check(d, pat(1 + k));
      check({7'h00, ok}, 8'h01);
    end
    m.bus_stop();
    check({7'h00, sdaOe}, 8'h00);
  endtask : t_current
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #10;
    fork
      m.idle_pulse();
    join_none
    repeat (20) @(posedge refClk);
    rst <= 1'b0;
    preload();
    repeat (4) @(posedge refClk);
    check({7'h00, sdaOe}, 8'h00);
    check({7'h00, sdaOut}, 8'h00);
    t_refuse();
    t_random();
    t_current();
    end_sim();
  end
  initial begin
    #400000;
    mismatches++;
    end_sim();
  end
endmodule : eeprom_sequential_read_tb
`default_nettype wire
